// ==== core/cwl_pkg.sv ====
// shared constants for the lock sideband, both ends
package cwl_pkg;

	////////////////////////////////////////////////////////////////////////
	// sideband widths
	localparam int NLOCK = 10;
	localparam int REV_W = 4;
	localparam int ECO_W = 36;
	localparam int TS_W = 64;
	localparam int DW = 32;

	// lock vector bit positions
	localparam int LK_SVEC = 0;
	localparam int LK_NSVEC = 1;
	localparam int LK_SPROT = 2;
	localparam int LK_NSPROT = 3;
	localparam int LK_ATTR = 4;
	localparam int LK_TCM = 5;
	localparam int LK_IGATE = 6;
	localparam int LK_DGATE = 7;
	localparam int LK_PBUS = 8;
	localparam int LK_ICACHE = 9;

	////////////////////////////////////////////////////////////////////////
	// device register indices
	localparam int IDX_W = 5;
	localparam logic [4:0] R_SVEC = 5'h00;
	localparam logic [4:0] R_NSVEC = 5'h01;
	localparam logic [4:0] R_APPINT = 5'h02;
	localparam logic [4:0] R_SPROT_FIRST = 5'h03;
	localparam logic [4:0] R_SPROT_LAST = 5'h08;
	localparam logic [4:0] R_NSPROT_FIRST = 5'h09;
	localparam logic [4:0] R_NSPROT_LAST = 5'h0e;
	localparam logic [4:0] R_ATTR_FIRST = 5'h0f;
	localparam logic [4:0] R_ATTR_LAST = 5'h12;
	localparam logic [4:0] R_ITCM = 5'h13;
	localparam logic [4:0] R_DTCM = 5'h14;
	localparam logic [4:0] R_IGATE_CTRL = 5'h15;
	localparam logic [4:0] R_IGATE_TABLE = 5'h16;
	localparam logic [4:0] R_DGATE_CTRL = 5'h17;
	localparam logic [4:0] R_DGATE_TABLE = 5'h18;
	localparam logic [4:0] R_PBUS = 5'h19;
	localparam logic [4:0] R_ICACHE_LOC = 5'h1a;
	localparam logic [4:0] R_ICACHE_READ = 5'h1b;
	localparam logic [4:0] R_REVID = 5'h1c;
	localparam int NSTORE = 27;

	// field masks inside the application interrupt control word and the peripheral bus word
	localparam logic [31:0] APPINT_PRIO = 32'h0000_0002;
	localparam logic [31:0] APPINT_FAULT = 32'h0000_0001;
	localparam logic [31:0] PBUS_ENABLE = 32'h0000_0001;

	////////////////////////////////////////////////////////////////////////
	// system end register byte offsets (ahb-lite)
	localparam logic [7:0] A_LOCK = 8'h00;
	localparam logic [7:0] A_TIEOFF = 8'h04;
	localparam logic [7:0] A_ECO_LO = 8'h08;
	localparam logic [7:0] A_ECO_HI = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_TS_CTRL = 8'h14;
	localparam logic [7:0] A_TS_LO = 8'h18;
	localparam logic [7:0] A_TS_HI = 8'h1c;
	localparam int ST_SEEN = 0;
	localparam int ST_ACTIVE = 1;
	localparam int TSC_EN = 0;
	localparam int TSC_RATIO_LSB = 8;
	localparam int RATIO_W = 8;

	// warm reset pulse length in core clock cycles
	localparam logic [4:0] WARM_RESET_CYCLES = 5'h10;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ==== core/cwl_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// sideband wires between system control logic and the core
interface cwl_if;
	logic [cwl_pkg::NLOCK-1:0] locks;
	logic [cwl_pkg::REV_W-1:0] revision_tieoff;
	logic [cwl_pkg::ECO_W-1:0] eng_change_revision;
	logic [cwl_pkg::TS_W-1:0] global_timestamp;
	logic timestamp_ratio_change;
	logic functional_reset_request;

	modport device (
		input locks,
		input revision_tieoff,
		input eng_change_revision,
		input global_timestamp,
		input timestamp_ratio_change,
		output functional_reset_request
	);
	modport system (
		output locks,
		output revision_tieoff,
		output eng_change_revision,
		output global_timestamp,
		output timestamp_ratio_change,
		input functional_reset_request
	);
endinterface
`default_nettype wire

// ==== core/cwl_device_end.sv ====
// Notes on behaviour
// - capture configuration inputs at reset, then hold
// - secure vector lock blocks secure vector writes
// - nonsecure vector lock blocks nonsecure offset writes
// - locks apply live to each write
// - without security extension secure offset inert
// - secure protection lock ignores its register writes
// - secure protection lock inert without extension/regions
// - nonsecure protection lock ignores writes if regions
// - attribution lock ignores writes if extension and regions
// - tight memory lock ignores both control writes
// - instruction gate lock blocks gate writes
// - data gate lock blocks gate writes
// - peripheral bus lock freezes port enable
// - icache lock: location and read registers zero
// - revision tie-off shows in revision register
// - system drives 36-bit change revision fields
// - core requests reset; system applies warm reset
// - system supplies 64-bit synchronous timestamp
// - system flags timestamp ratio change
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cwl_device_end #(
	parameter bit SECURITY_EXT = 1'b1,
	parameter int SECURE_REGIONS = 8,
	parameter int NONSECURE_REGIONS = 8,
	parameter int ATTRIBUTION_REGIONS = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// sideband towards system control
	cwl_if.device sb,
	// core register access port
	input wire logic acc_write,
	input wire logic acc_read,
	input wire logic [cwl_pkg::IDX_W-1:0] acc_index,
	input wire logic [cwl_pkg::DW-1:0] acc_wdata,
	output logic [cwl_pkg::DW-1:0] acc_rdata,
	output logic acc_rvalid,
	output logic acc_blocked,
	// cache raw content and reset request from the core
	input wire logic [cwl_pkg::DW-1:0] cache_read_data,
	input wire logic reset_request_in,
	// captured configuration and live controls
	output logic config_valid,
	output logic [cwl_pkg::REV_W-1:0] revision_out,
	output logic [cwl_pkg::ECO_W-1:0] eco_out,
	output logic [cwl_pkg::TS_W-1:0] timestamp_out,
	output logic ratio_changed,
	output logic [cwl_pkg::DW-1:0] secure_vector_base,
	output logic [cwl_pkg::DW-1:0] nonsecure_vector_base,
	output logic peripheral_port_enable
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [cwl_pkg::NSTORE-1:0][cwl_pkg::DW-1:0] regs;
		logic [cwl_pkg::DW-1:0] rdata;
		logic rvalid;
		logic blocked;
		logic captured;
		logic [cwl_pkg::REV_W-1:0] rev;
		logic [cwl_pkg::ECO_W-1:0] eco;
		logic [cwl_pkg::TS_W-1:0] ts;
		logic ratio;
		logic rstreq;
	} cwl_dev_s;

	cwl_dev_s s;
	cwl_dev_s next_s;

	// lock qualifiers that depend on the build options
	// a region count of zero leaves the matching lock without effect
	localparam bit SPROT_ACTIVE = SECURITY_EXT && (SECURE_REGIONS > 0);
	localparam bit NSPROT_ACTIVE = NONSECURE_REGIONS > 0;
	localparam bit ATTR_ACTIVE = SECURITY_EXT && (ATTRIBUTION_REGIONS > 0);

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic in_range(input logic [4:0] idx, input logic [4:0] lo,
		input logic [4:0] hi);
		in_range = (idx >= lo) && (idx <= hi);
	endfunction

	// true when a whole-word write to idx must be dropped under the live locks
	function automatic logic write_locked(input logic [4:0] idx,
		input logic [cwl_pkg::NLOCK-1:0] lk);
		logic r;
		r = 1'b0;
		if (idx == cwl_pkg::R_NSVEC)
			r = lk[cwl_pkg::LK_NSVEC];
		if (in_range(idx, cwl_pkg::R_SPROT_FIRST, cwl_pkg::R_SPROT_LAST))
			r = lk[cwl_pkg::LK_SPROT] && SPROT_ACTIVE;
		if (in_range(idx, cwl_pkg::R_NSPROT_FIRST, cwl_pkg::R_NSPROT_LAST))
			r = lk[cwl_pkg::LK_NSPROT] && NSPROT_ACTIVE;
		if (in_range(idx, cwl_pkg::R_ATTR_FIRST, cwl_pkg::R_ATTR_LAST))
			r = lk[cwl_pkg::LK_ATTR] && ATTR_ACTIVE;
		if ((idx == cwl_pkg::R_ITCM) || (idx == cwl_pkg::R_DTCM))
			r = lk[cwl_pkg::LK_TCM];
		if ((idx == cwl_pkg::R_IGATE_CTRL) || (idx == cwl_pkg::R_IGATE_TABLE))
			r = lk[cwl_pkg::LK_IGATE];
		if ((idx == cwl_pkg::R_DGATE_CTRL) || (idx == cwl_pkg::R_DGATE_TABLE))
			r = lk[cwl_pkg::LK_DGATE];
		if (idx == cwl_pkg::R_PBUS)
			r = lk[cwl_pkg::LK_PBUS];
		if (idx == cwl_pkg::R_ICACHE_LOC)
			r = lk[cwl_pkg::LK_ICACHE];
		write_locked = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [cwl_pkg::DW-1:0] wmask;
		logic svlock;
		wmask = '1;
		// the secure vector lock is inert without the security extension
		svlock = sb.locks[cwl_pkg::LK_SVEC] && SECURITY_EXT;
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.blocked = 1'b0;
		// timestamp and ratio flag are synchronous to hclk, registered once
		next_s.ts = sb.global_timestamp;
		next_s.ratio = sb.timestamp_ratio_change;
		next_s.rstreq = reset_request_in;
		// first edge after reset release samples the tie-offs once
		if (!s.captured) begin
			next_s.captured = 1'b1;
			next_s.rev = sb.revision_tieoff;
			next_s.eco = sb.eng_change_revision;
		end
		// writes, checked against the lock level of this very cycle
		if (acc_write) begin
			if (acc_index == cwl_pkg::R_APPINT) begin
				// only the priority and fault target bits are guarded, the rest lands
				if (svlock) begin
					wmask = ~(cwl_pkg::APPINT_PRIO | cwl_pkg::APPINT_FAULT);
					next_s.blocked = 1'b1;
				end
				next_s.regs[acc_index] = (s.regs[acc_index] & ~wmask) | (acc_wdata & wmask);
			end else if (acc_index == cwl_pkg::R_SVEC) begin
				if (!SECURITY_EXT) begin
					next_s.regs[acc_index] = s.regs[acc_index];
				end else if (svlock) begin
					next_s.blocked = 1'b1;
				end else begin
					next_s.regs[acc_index] = acc_wdata;
				end
			end else if (acc_index < cwl_pkg::IDX_W'(cwl_pkg::NSTORE)) begin
				if (write_locked(acc_index, sb.locks))
					next_s.blocked = 1'b1;
				else
					next_s.regs[acc_index] = acc_wdata;
			end
		end
		// reads outside the cache words return stored content regardless of locks
		// cache direct-access words read as zero while their lock is high
		if (acc_read) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = '0;
			if (acc_index == cwl_pkg::R_REVID)
				next_s.rdata = {{(cwl_pkg::DW-cwl_pkg::REV_W){1'b0}}, s.rev};
			else if (acc_index == cwl_pkg::R_ICACHE_READ)
				next_s.rdata = sb.locks[cwl_pkg::LK_ICACHE] ? '0 : cache_read_data;
			else if (acc_index == cwl_pkg::R_ICACHE_LOC)
				next_s.rdata = sb.locks[cwl_pkg::LK_ICACHE] ? '0 : s.regs[acc_index];
			else if (acc_index == cwl_pkg::R_SVEC)
				next_s.rdata = SECURITY_EXT ? s.regs[acc_index] : '0;
			else if (acc_index < cwl_pkg::IDX_W'(cwl_pkg::NSTORE))
				next_s.rdata = s.regs[acc_index];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	// cold or warm reset clears every stored word and rearms the capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	// the secure base reads as zero when the extension is absent
	assign acc_rdata = s.rdata;
	assign acc_rvalid = s.rvalid;
	assign acc_blocked = s.blocked;
	assign config_valid = s.captured;
	assign revision_out = s.rev;
	assign eco_out = s.eco;
	assign timestamp_out = s.ts;
	assign ratio_changed = s.ratio;
	assign sb.functional_reset_request = s.rstreq;
	assign secure_vector_base = SECURITY_EXT ? s.regs[cwl_pkg::R_SVEC] : '0;
	assign nonsecure_vector_base = s.regs[cwl_pkg::R_NSVEC];
	assign peripheral_port_enable = |(s.regs[cwl_pkg::R_PBUS] & cwl_pkg::PBUS_ENABLE);

endmodule
`default_nettype wire

// ==== core/cwl_system_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module cwl_system_end (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	// sideband towards the core
	cwl_if.system sb,
	// warm reset for the core
	output logic warm_reset_n
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic [cwl_pkg::NLOCK-1:0] locks;
		logic [cwl_pkg::REV_W-1:0] rev;
		logic [cwl_pkg::ECO_W-1:0] eco;
		logic ts_en;
		logic [cwl_pkg::RATIO_W-1:0] ratio;
		logic [cwl_pkg::RATIO_W-1:0] div;
		logic [cwl_pkg::TS_W-1:0] ts;
		logic ratio_pulse;
		logic req_prev;
		logic seen;
		logic [4:0] warm_cnt;
	} cwl_sys_s;

	cwl_sys_s s;
	cwl_sys_s next_s;

	////////////////////////////////////////////////////////////////////////
	// next state: register writes, timestamp, warm reset, read capture
	always_comb begin
		logic wr;
		logic req_rise;
		logic clr_seen;
		wr = s.dp_valid && s.dp_write;
		req_rise = sb.functional_reset_request && !s.req_prev;
		clr_seen = 1'b0;
		next_s = s;
		next_s.ratio_pulse = 1'b0;
		next_s.req_prev = sb.functional_reset_request;
		// data phase of a write
		if (wr) begin
			unique case (s.dp_addr)
				cwl_pkg::A_LOCK: next_s.locks = hwdata[cwl_pkg::NLOCK-1:0];
				cwl_pkg::A_TIEOFF: next_s.rev = hwdata[cwl_pkg::REV_W-1:0];
				cwl_pkg::A_ECO_LO: next_s.eco[31:0] = hwdata;
				cwl_pkg::A_ECO_HI: next_s.eco[cwl_pkg::ECO_W-1:32] = hwdata[3:0];
				cwl_pkg::A_STATUS: clr_seen = hwdata[cwl_pkg::ST_SEEN];
				cwl_pkg::A_TS_CTRL: begin
					next_s.ts_en = hwdata[cwl_pkg::TSC_EN];
					next_s.ratio = hwdata[cwl_pkg::TSC_RATIO_LSB +: cwl_pkg::RATIO_W];
					// a new ratio is announced to the core
					next_s.ratio_pulse = next_s.ratio != s.ratio;
					next_s.div = '0;
				end
				default: ;
			endcase
		end
		// timestamp advances once per ratio+1 cycles
		if (s.ts_en && !(wr && (s.dp_addr == cwl_pkg::A_TS_CTRL))) begin
			if (s.div == s.ratio) begin
				next_s.div = '0;
				next_s.ts = s.ts + 64'h1;
			end else begin
				next_s.div = s.div + 8'h1;
			end
		end
		// sticky request flag, a new request wins over a clear
		next_s.seen = (s.seen && !clr_seen) || req_rise;
		// request edge starts a fixed warm reset pulse
		if (s.warm_cnt != 5'h0)
			next_s.warm_cnt = s.warm_cnt - 5'h1;
		else if (req_rise)
			next_s.warm_cnt = cwl_pkg::WARM_RESET_CYCLES;
		// address phase
		next_s.dp_valid = hsel && hready && htrans[1];
		next_s.dp_write = hwrite;
		next_s.dp_addr = haddr[7:0];
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				cwl_pkg::A_LOCK: next_s.rdata = 32'(next_s.locks);
				cwl_pkg::A_TIEOFF: next_s.rdata = 32'(next_s.rev);
				cwl_pkg::A_ECO_LO: next_s.rdata = next_s.eco[31:0];
				cwl_pkg::A_ECO_HI: next_s.rdata = 32'(next_s.eco[cwl_pkg::ECO_W-1:32]);
				cwl_pkg::A_STATUS: begin
					next_s.rdata = '0;
					next_s.rdata[cwl_pkg::ST_SEEN] = next_s.seen;
					next_s.rdata[cwl_pkg::ST_ACTIVE] = next_s.warm_cnt != 5'h0;
				end
				cwl_pkg::A_TS_CTRL: begin
					next_s.rdata = '0;
					next_s.rdata[cwl_pkg::TSC_EN] = next_s.ts_en;
					next_s.rdata[cwl_pkg::TSC_RATIO_LSB +: cwl_pkg::RATIO_W] = next_s.ratio;
				end
				cwl_pkg::A_TS_LO: next_s.rdata = next_s.ts[31:0];
				cwl_pkg::A_TS_HI: next_s.rdata = next_s.ts[63:32];
				default: next_s.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = cwl_pkg::HRESP_OKAY;
	assign hrdata = s.rdata;
	assign sb.locks = s.locks;
	assign sb.revision_tieoff = s.rev;
	assign sb.eng_change_revision = s.eco;
	assign sb.global_timestamp = s.ts;
	assign sb.timestamp_ratio_change = s.ratio_pulse;
	assign warm_reset_n = s.warm_cnt == 5'h0;

endmodule
`default_nettype wire

// ==== testbench/cwl_sideband_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
// watches the sideband that joins the two ends
module cwl_sideband_sva (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// sideband
	input wire logic [cwl_pkg::NLOCK-1:0] locks,
	input wire logic [cwl_pkg::REV_W-1:0] revision_tieoff,
	input wire logic [cwl_pkg::ECO_W-1:0] eng_change_revision,
	input wire logic [cwl_pkg::TS_W-1:0] global_timestamp,
	input wire logic timestamp_ratio_change,
	input wire logic functional_reset_request,
	// warm reset answer from the system end
	input wire logic warm_reset_n
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////
	// ratio flag is a one cycle pulse
	sequence flag_pulse_s;
		timestamp_ratio_change ##1 !timestamp_ratio_change;
	endsequence
	ratio_pulse_a: assert property ($rose(timestamp_ratio_change) |-> flag_pulse_s)
		else $error("ratio flag held longer than one cycle");
	// timestamp holds or counts up by one
	timestamp_step_a: assert property (global_timestamp == $past(global_timestamp)
		|| global_timestamp == $past(global_timestamp) + 64'h1)
		else $error("timestamp jumped");
	// a request is answered by a warm reset that clears it
	request_answer_a: assert property ($rose(functional_reset_request)
		|-> ##[1:4] !functional_reset_request)
		else $error("reset request not answered");
	// a request edge, seen over two samples
	sequence req_rise_s;
		!functional_reset_request ##1 functional_reset_request;
	endsequence
	// the system answers a request edge with a warm reset pulse
	warm_applied_a: assert property (req_rise_s
		|=> !warm_reset_n [*8])
		else $error("warm reset not applied after request");
	// the core stays quiet for the first 8 cycles of its warm reset
	request_held_a: assert property (req_rise_s
		|=> !functional_reset_request [*8])
		else $error("request raised again during warm reset");
	// a ratio change restarts the divider, so the count holds that cycle
	timestamp_quiet_a: assert property (timestamp_ratio_change
		|-> $stable(global_timestamp))
		else $error("timestamp moved on a ratio change");
	// main events are reached
	cover property (timestamp_ratio_change);
	cover property (functional_reset_request);
endmodule
`default_nettype wire

// ==== testbench/config_write_lock_sideband_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
// drives both ends and judges what comes back
module config_write_lock_sideband_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic acc_write = 1'b0;
	logic acc_read = 1'b0;
	logic reset_request_in = 1'b0;
	logic [4:0] acc_index = 5'h0;
	logic [31:0] acc_wdata = 32'h0;
	logic hreadyout, warm_reset_n, dev_rst_n, acc_rvalid, acc_blocked, config_valid;
	logic ratio_changed, peripheral_port_enable;
	logic [1:0] hresp;
	logic [31:0] hrdata, v, d, acc_rdata, secure_vector_base, nonsecure_vector_base;
	logic [3:0] revision_out;
	logic [35:0] eco_out;
	logic [63:0] timestamp_out, t;
	logic bare_blocked;
	logic [31:0] bare_rdata, bare_svec;
	int n_fail = 0;
	int n_checks = 0;
	int n_pulse = 0;
	int k;
	// guarded register indices and the lock bit of each
	localparam logic [4:0] IX [15] = '{5'h00, 5'h01, 5'h03, 5'h08, 5'h09, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19};
	localparam int LB [15] = '{0, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7, 7, 8};

	cwl_if sb_if ();
	cwl_if sb2_if ();
	assign dev_rst_n = hresetn & warm_reset_n;
	cwl_device_end i_cwl_device_end (.hclk(hclk), .hresetn(dev_rst_n), .sb(sb_if),
		.acc_write(acc_write), .acc_read(acc_read), .acc_index(acc_index),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
		.acc_blocked(acc_blocked), .cache_read_data(32'hc0de_0042),
		.reset_request_in(reset_request_in), .config_valid(config_valid),
		.revision_out(revision_out), .eco_out(eco_out), .timestamp_out(timestamp_out),
		.ratio_changed(ratio_changed), .secure_vector_base(secure_vector_base),
		.nonsecure_vector_base(nonsecure_vector_base),
		.peripheral_port_enable(peripheral_port_enable));
	cwl_system_end i_cwl_system_end (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sb(sb_if), .warm_reset_n(warm_reset_n));
	cwl_sideband_sva i_cwl_sideband_sva (.hclk(hclk), .hresetn(hresetn),
		.locks(sb_if.locks), .revision_tieoff(sb_if.revision_tieoff),
		.eng_change_revision(sb_if.eng_change_revision),
		.global_timestamp(sb_if.global_timestamp),
		.timestamp_ratio_change(sb_if.timestamp_ratio_change),
		.functional_reset_request(sb_if.functional_reset_request), .warm_reset_n(warm_reset_n));
	// second core built without the security extension and without regions
	assign sb2_if.locks = sb_if.locks;
	assign sb2_if.revision_tieoff = sb_if.revision_tieoff;
	assign sb2_if.eng_change_revision = sb_if.eng_change_revision;
	assign sb2_if.global_timestamp = sb_if.global_timestamp;
	assign sb2_if.timestamp_ratio_change = sb_if.timestamp_ratio_change;
	cwl_device_end #(.SECURITY_EXT(1'b0), .SECURE_REGIONS(0), .NONSECURE_REGIONS(0),
		.ATTRIBUTION_REGIONS(0)) i_cwl_device_end_bare (.hclk(hclk), .hresetn(dev_rst_n),
		.sb(sb2_if), .acc_write(acc_write), .acc_read(acc_read), .acc_index(acc_index),
		.acc_wdata(acc_wdata), .acc_rdata(bare_rdata), .acc_rvalid(),
		.acc_blocked(bare_blocked), .cache_read_data(32'h0), .reset_request_in(1'b0),
		.config_valid(), .revision_out(), .eco_out(), .timestamp_out(), .ratio_changed(),
		.secure_vector_base(bare_svec), .nonsecure_vector_base(),
		.peripheral_port_enable());

	always #5 hclk = ~hclk;
	// counts ratio change pulses
	always @(posedge hclk) begin
		if (sb_if.timestamp_ratio_change === 1'b1) n_pulse++;
	end
	////////////////////////////////////////////////////////////
	// verdict and end of run
	task complete_run;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic pick(input int s);
		return (s == 0) ? hreadyout : warm_reset_n;
	endfunction
	// bounded wait for a level, k counts the edges
	task automatic await(input int s, input logic lv, output int n);
		for (n = 0; pick(s) !== lv; n++) begin
			if (n == 60) begin
				n_fail++;
				complete_run;
			end
			@(posedge hclk);
		end
	endtask
	// one single ahb-lite word transfer
	task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		await(0, 1'b1, k);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		await(0, 1'b1, k);
		rd = hrdata;
	endtask
	// one device register access, outputs settled on return
	task dev(input logic w, input logic [4:0] i, input logic [31:0] wd);
		@(posedge hclk);
		acc_write <= w;
		acc_read <= !w;
		acc_index <= i;
		acc_wdata <= wd;
		@(posedge hclk);
		acc_write <= 1'b0;
		acc_read <= 1'b0;
		#1;
	endtask
	// tie-offs taken only at reset, warm reset on request
	task s_capture;
		ahb(cwl_pkg::A_TIEOFF, 1'b1, 32'h5, v);
		ahb(cwl_pkg::A_ECO_LO, 1'b1, 32'h8765_4321, v);
		ahb(cwl_pkg::A_ECO_HI, 1'b1, 32'h9, v);
		`CHK(revision_out, 4'h0);
		reset_request_in <= 1'b1;
		await(1, 1'b0, k);
		reset_request_in <= 1'b0;
		await(1, 1'b1, k);
		`CHK(k, 16);
		dev(1'b0, cwl_pkg::R_REVID, 32'h0);
		`CHK(acc_rvalid, 1'b1);
		`CHK(acc_rdata, 32'h5);
		`CHK(config_valid, 1'b1);
		`CHK(eco_out, 36'h9_8765_4321);
		ahb(cwl_pkg::A_STATUS, 1'b0, 32'h0, v);
		`CHK(v[0], 1'b1);
		`CHK(v[1], 1'b0);
		ahb(cwl_pkg::A_TIEOFF, 1'b1, 32'h9, v);
		`CHK(revision_out, 4'h5);
	endtask
	// each lock up to the peripheral bus lock blocks its own registers only, live
	task s_locks;
		for (int i = 0; i < 15; i++) begin
			d = 32'h5a5a_0001 | {19'h0, IX[i], 8'h0};
			ahb(cwl_pkg::A_LOCK, 1'b1, {22'h0, ~(10'h1 << LB[i])}, v);
			dev(1'b1, IX[i], d);
			`CHK(acc_blocked, 1'b0);
			ahb(cwl_pkg::A_LOCK, 1'b1, 32'h1 << LB[i], v);
			dev(1'b1, IX[i], 32'ha5a5_0000);
			`CHK(acc_blocked, 1'b1);
			dev(1'b0, IX[i], 32'h0);
			`CHK(acc_rdata, d);
		end
		`CHK(secure_vector_base, 32'h5a5a_0001);
		`CHK(nonsecure_vector_base, 32'h5a5a_0101);
		`CHK(peripheral_port_enable, 1'b1);
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h0, v);
		dev(1'b1, cwl_pkg::R_APPINT, 32'h0);
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h1, v);
		dev(1'b1, cwl_pkg::R_APPINT, 32'hffff_ffff);
		`CHK(acc_blocked, 1'b1);
		dev(1'b0, cwl_pkg::R_APPINT, 32'h0);
		`CHK(acc_rdata, 32'hffff_fffc);
	endtask
	// cache access registers read as zero under their lock
	task s_icache;
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h0, v);
		dev(1'b1, 5'h1a, 32'h40);
		dev(1'b0, 5'h1a, 32'h0);
		`CHK(acc_rdata, 32'h40);
		dev(1'b0, 5'h1b, 32'h0);
		`CHK(acc_rdata, 32'hc0de_0042);
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h200, v);
		dev(1'b1, 5'h1a, 32'h80);
		`CHK(acc_blocked, 1'b1);
		dev(1'b0, 5'h1a, 32'h0);
		`CHK(acc_rdata, 32'h0);
		dev(1'b0, 5'h1b, 32'h0);
		`CHK(acc_rdata, 32'h0);
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h0, v);
		dev(1'b0, 5'h1a, 32'h0);
		`CHK(acc_rdata, 32'h40);
	endtask
	// without the extension the secure locks and the secure offset are inert
	task s_bare;
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h3ff, v);
		dev(1'b1, cwl_pkg::R_SVEC, 32'h1234_5678);
		`CHK(bare_blocked, 1'b0);
		dev(1'b0, cwl_pkg::R_SVEC, 32'h0);
		`CHK(bare_rdata, 32'h0);
		`CHK(bare_svec, 32'h0);
		for (int i = 2; i < 8; i++) begin
			dev(1'b1, IX[i], 32'h3c3c_0000 | i);
			`CHK(bare_blocked, 1'b0);
			dev(1'b0, IX[i], 32'h0);
			`CHK(bare_rdata, 32'h3c3c_0000 | i);
		end
		dev(1'b1, cwl_pkg::R_APPINT, 32'hffff_ffff);
		`CHK(bare_blocked, 1'b0);
		dev(1'b1, cwl_pkg::R_NSVEC, 32'h0);
		`CHK(bare_blocked, 1'b1);
		ahb(cwl_pkg::A_LOCK, 1'b1, 32'h0, v);
	endtask
	// ratio change flag and timestamp rate
	task s_timestamp;
		ahb(cwl_pkg::A_TS_CTRL, 1'b1, 32'h0301, v);
		repeat (3) @(posedge hclk);
		`CHK(n_pulse, 1);
		t = timestamp_out;
		repeat (8) @(posedge hclk);
		`CHK(timestamp_out, t + 64'h2);
		ahb(cwl_pkg::A_TS_CTRL, 1'b1, 32'h0301, v);
		repeat (3) @(posedge hclk);
		`CHK(n_pulse, 1);
		ahb(cwl_pkg::A_TS_CTRL, 1'b1, 32'h0501, v);
		repeat (2) @(posedge hclk);
		`CHK(ratio_changed, 1'b1);
		@(posedge hclk);
		`CHK(ratio_changed, 1'b0);
		`CHK(n_pulse, 2);
	endtask
	// unmapped offset reads zero and hits nothing
	task s_unmapped;
		ahb(8'h24, 1'b1, 32'hffff_ffff, v);
		ahb(8'h24, 1'b0, 32'h0, v);
		`CHK(v, 32'h0);
		`CHK(hresp, 2'h0);
		ahb(cwl_pkg::A_LOCK, 1'b0, 32'h0, v);
		`CHK(v, 32'h0);
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		s_capture;
		s_locks;
		s_icache;
		s_bare;
		s_timestamp;
		s_unmapped;
		complete_run;
	end
endmodule
`default_nettype wire
